// File: hdl/tws_channel.v
/*
  three-wire synchronous serial channel: mode register, 8-bit shift register,
  clock divider, external clock sampler and pin control.
  assumes a cpu-side byte port (address, write and read strobes) on core_clk_i,
  and that core_clk_i stands for the main oscillator; pins are synchronous.
*/
// Operation
// - three lines, clock, serial out and serial in, full duplex.
// - each 8-bit transfer sends msb first, always.
// - 8-bit mode register written whole; enable bit also settable alone.
// - reset clears the mode register: disabled, external clock.
// - code 00 takes external clock, clock pin is input; 01 never used.
// - code 10 divides main clock by 16, 11 by 8; pin drives.
// - enable low: no shift, counter cleared, flag held, data pins are port pins; clock pin still driven high if divider selected.
// - enable high: shifting, counter counts, flag may set, serial pins.
// - shift register converts parallel to serial, one bit per clock.
// - writing shift register starts transfer; whole byte readable and writable.
// - written byte goes out serial out; serial in bits gather in register.
// - reset mid-transfer leaves data undefined; standby reset keeps it.
// - shifting stops by itself after eight bits.
// - start needs enable already set, clock masked, clock line high.
// - shift out on falling clock edge from a separate output latch.
// - serial in captured on each rising clock edge.
// - after eight bits shifting stops and the end flag is set.
// - reset gives halt mode: no shifting, data pins act as inputs.
`include "tws_consts.vh"
`default_nettype none

module tws_channel #(
  parameter integer DATA_W = 8
) (
  input  wire                   core_clk_i,
  input  wire                   rst_i,
  input  wire [`TWS_ADDR_W-1:0] addr_i,
  input  wire [DATA_W-1:0]      wdata_i,
  input  wire                   wr_i,
  input  wire                   enable_set_i,
  input  wire                   rd_i,
  output reg  [DATA_W-1:0]      rdata_o,
  output reg                    transfer_end_flag_o,
  input  wire                   flag_clr_i,
  input  wire                   ch1_clock_pin_i,
  output reg                    ch1_clock_pin_o,
  output reg                    ch1_clock_pin_oe_o,
  output reg                    ch1_serial_out_o,
  output reg                    ch1_serial_out_oe_o,
  input  wire                   ch1_serial_in_i,
  output reg                    serial_function_o
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_SHIFT = 2'b10;

  reg [7:0]        mode_q;
  reg [DATA_W-1:0] shreg_q;
  reg [1:0]        state_q;
  reg [3:0]        bitcnt_q;     // serial clock counter
  reg [3:0]        divcnt_q;
  reg              sck_q;        // internal serial clock level
  reg              ext_prev_q;   // previous sample of the external clock
  reg              out_latch_q;  // serial out latch

  wire       enable   = mode_q[`TWS_ENABLE_BIT];
  wire [1:0] csel     = {mode_q[`TWS_CSEL_HI_BIT], mode_q[`TWS_CSEL_LO_BIT]};
  wire       internal = csel[1];
  wire       wr_mode  = wr_i && (addr_i == `TWS_MODE_OFFSET);
  wire       wr_shift = wr_i && (addr_i == `TWS_SHIFT_OFFSET);
  wire       busy     = state_q[1];

  // clock level seen by the shifter: internal divider or external pin
  wire       sck_now  = internal ? sck_q : ch1_clock_pin_i;

  // half-period length for the selected divider
  function [3:0] half_len;
    input [1:0] sel;
    begin
      half_len = (sel == `TWS_CSEL_DIV8) ? `TWS_DIV8_HALF : `TWS_DIV16_HALF;
    end
  endfunction

  // edge events of the serial clock while a transfer runs
  reg sck_fall;
  reg sck_rise;
  always @* begin
    sck_fall = 1'b0;
    sck_rise = 1'b0;
    if (busy && enable) begin
      if (internal) begin
        sck_fall = sck_q && (divcnt_q == half_len(csel) - 4'h1);
        sck_rise = !sck_q && (divcnt_q == half_len(csel) - 4'h1);
      end else begin
        sck_fall = ext_prev_q && !ch1_clock_pin_i;
        sck_rise = !ext_prev_q && ch1_clock_pin_i;
      end
    end
  end

  // start only with enable already set, clock masked and line high
  wire start = wr_shift && enable && !busy && sck_now;

  // --------------------------------------------------------------------------
  // mode register
  // --------------------------------------------------------------------------
  // whole-byte write, plus a single-bit enable set; reserved bits kept as 0
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      mode_q <= `TWS_MODE_RESET;
    end else if (wr_mode) begin
      mode_q <= {wdata_i[7], 5'h00, wdata_i[1:0]};
    end else if (enable_set_i) begin
      mode_q[`TWS_ENABLE_BIT] <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // transfer sequencer, divider and shift register
  // --------------------------------------------------------------------------
  // shreg_q has no reset so standby content survives; a reset mid-transfer
  // simply aborts, leaving whatever bits were shifted in
  always @(posedge core_clk_i) begin
    if (wr_shift && !busy) begin
      shreg_q <= wdata_i;
    end else if (sck_rise) begin
      shreg_q <= {shreg_q[DATA_W-2:0], ch1_serial_in_i};
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q     <= ST_IDLE;
      bitcnt_q    <= 4'h0;
      divcnt_q    <= 4'h0;
      sck_q       <= 1'b1;
      ext_prev_q  <= 1'b1;
      out_latch_q <= 1'b1;
    end else begin
      ext_prev_q <= ch1_clock_pin_i;
      if (!enable) begin
        state_q  <= ST_IDLE;
        bitcnt_q <= 4'h0;
        divcnt_q <= 4'h0;
        sck_q    <= 1'b1;
      end else begin
        case (state_q)
          ST_IDLE: begin
            sck_q    <= 1'b1;
            divcnt_q <= 4'h0;
            if (start) begin
              state_q  <= ST_SHIFT;
              bitcnt_q <= 4'h0;
            end
          end
          ST_SHIFT: begin
            if (internal) begin
              if (divcnt_q == half_len(csel) - 4'h1) begin
                divcnt_q <= 4'h0;
                sck_q    <= !sck_q;
              end else begin
                divcnt_q <= divcnt_q + 4'h1;
              end
            end
            if (sck_fall) begin
              out_latch_q <= shreg_q[DATA_W-1];
            end
            if (sck_rise) begin
              bitcnt_q <= bitcnt_q + 4'h1;
              if (bitcnt_q == `TWS_BITS - 4'h1) begin
                state_q <= ST_IDLE;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // end flag: set wins over clear, held while disabled
  // --------------------------------------------------------------------------
  wire done = sck_rise && (bitcnt_q == `TWS_BITS - 4'h1);
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      transfer_end_flag_o <= 1'b0;
    end else if (done) begin
      transfer_end_flag_o <= 1'b1;
    end else if (flag_clr_i) begin
      transfer_end_flag_o <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // pins and read data, all registered
  // --------------------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      ch1_clock_pin_o     <= 1'b1;
      ch1_clock_pin_oe_o  <= 1'b0;
      ch1_serial_out_o    <= 1'b1;
      ch1_serial_out_oe_o <= 1'b0;
      serial_function_o   <= 1'b0;
      rdata_o             <= {DATA_W{1'b0}};
    end else begin
      // next-cycle clock level so the pin tracks the internal clock
      ch1_clock_pin_o     <= (internal && busy && enable) ?
                             (sck_fall ? 1'b0 : (sck_rise ? 1'b1 : sck_q)) : 1'b1;
      ch1_clock_pin_oe_o  <= internal;
      ch1_serial_out_o    <= sck_fall ? shreg_q[DATA_W-1] : out_latch_q;
      ch1_serial_out_oe_o <= enable;
      serial_function_o   <= enable;
      if (rd_i && addr_i == `TWS_SHIFT_OFFSET) begin
        rdata_o <= shreg_q;
      end else begin
        rdata_o <= {DATA_W{1'b0}};
      end
    end
  end

endmodule // tws_channel

`default_nettype wire

// File: common/tws_consts.vh
/*
  constants for the three-wire serial channel: register offsets, field positions,
  reset values and clock divider figures. assumes nothing of its surroundings.
*/
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define TWS_ADDR_W        12
`define TWS_MODE_OFFSET   12'hFC8
`define TWS_SHIFT_OFFSET  12'hFC9
`define TWS_MODE_RESET    8'h00

// ----------------------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------------------
`define TWS_ENABLE_BIT    7
`define TWS_CSEL_HI_BIT   1
`define TWS_CSEL_LO_BIT   0
`define TWS_CSEL_EXT      2'h0
`define TWS_CSEL_RSVD     2'h1
`define TWS_CSEL_DIV16    2'h2
`define TWS_CSEL_DIV8     2'h3

// ----------------------------------------------------------------------------
// timing: half serial clock period in main clock cycles, and bits per transfer
// ----------------------------------------------------------------------------
`define TWS_DIV16_HALF    4'h8
`define TWS_DIV8_HALF     4'h4
`define TWS_BITS          4'h8

`endif

// File: dv/tws_channel_assertions.sv
/* port checker for tws_channel.
   assumes it is bound to the top module and sees only its ports. */
`include "tws_consts.vh"
`default_nettype none
module tws_channel_assertions #(
  parameter integer DATA_W = 8
) (
  input wire logic              core_clk_i,
  input wire logic              rst_i,
  input wire logic [11:0]       addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              transfer_end_flag_o,
  input wire logic              flag_clr_i,
  input wire logic              ch1_clock_pin_o,
  input wire logic              ch1_clock_pin_oe_o,
  input wire logic              ch1_serial_out_oe_o,
  input wire logic              serial_function_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------
  // properties
  // ---------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_int_wr; wr_i && addr_i == `TWS_MODE_OFFSET && wdata_i[1]; endsequence
  sequence s_idle8; ch1_clock_pin_o [*8]; endsequence
  property p_int_oe; s_int_wr |-> ##[1:2] ch1_clock_pin_oe_o; endproperty
  property p_fn_eq; serial_function_o == ch1_serial_out_oe_o; endproperty
  property p_mode_wo; rd_i && addr_i == `TWS_MODE_OFFSET |=> rdata_o == 8'h00; endproperty
  property p_rd_one; !rd_i |=> rdata_o == 8'h00; endproperty
  property p_flag_hold; transfer_end_flag_o && !flag_clr_i |=> transfer_end_flag_o; endproperty
  property p_rst_out;
    $fell(rst_i) |-> ch1_clock_pin_o && !ch1_clock_pin_oe_o && !serial_function_o;
  endproperty
  // disabled channel must not clock, even with the divider selected
  property p_idle_hi;
    !serial_function_o && !$past(serial_function_o) && ch1_clock_pin_oe_o |-> ch1_clock_pin_o;
  endproperty
  property p_end_idle; $rose(transfer_end_flag_o) && ch1_clock_pin_oe_o |-> s_idle8; endproperty
  a_int_oe: assert property (p_int_oe) else $error("clock pin not driven");
  a_fn_eq: assert property (p_fn_eq) else $error("pin function split");
  a_mode_wo: assert property (p_mode_wo) else $error("mode register readable");
  a_rd_one: assert property (p_rd_one) else $error("read data lingers");
  a_flag_hold: assert property (p_flag_hold) else $error("end flag lost");
  a_rst_out: assert property (p_rst_out) else $error("pins not in halt state");
  a_idle_hi: assert property (p_idle_hi) else $error("clock low while off");
  a_end_idle: assert property (p_end_idle) else $error("clock runs past 8 bits");
endmodule // tws_channel_assertions
bind tws_channel tws_channel_assertions #(.DATA_W(DATA_W)) i_tws_channel_assertions (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .transfer_end_flag_o(transfer_end_flag_o),
  .flag_clr_i(flag_clr_i), .ch1_clock_pin_o(ch1_clock_pin_o),
  .ch1_clock_pin_oe_o(ch1_clock_pin_oe_o), .ch1_serial_out_oe_o(ch1_serial_out_oe_o),
  .serial_function_o(serial_function_o));
`default_nettype wire

// File: dv/tws_peer.sv
/* far-end serial peripheral: swaps one byte msb first.
   assumes the bench resolves the clock line level. */
`default_nettype none
module tws_peer (
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       load_i,
  input  wire logic [7:0] tx_i,
  output var  logic       miso_o,
  output var  logic [7:0] rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh_q;
  // idle line shows inverse of bit 7 so an early sample is caught
  always @(posedge load_i) begin
    sh_q = tx_i;
    miso_o = ~tx_i[7];
  end
  // send on falling edge, capture on rising edge
  always @(negedge sck_i) begin
    miso_o = sh_q[7];
    sh_q = {sh_q[6:0], 1'b0};
  end
  always @(posedge sck_i) rx_o = {rx_o[6:0], mosi_i};
endmodule // tws_peer
`default_nettype wire

// File: dv/tws_channel_tb_top.sv
/* bench for tws_channel: register tasks, far-end peer, one task per scenario.
   assumes peer model and checker compiled first. */
`include "tws_consts.vh"
`default_nettype none
module tws_channel_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, es = 0, clr = 0, ld = 0, ext = 1;
  logic [11:0] addr = 0;
  logic [7:0]  wd = 0, rdv, rdata, ptx = 0, prx;
  logic        flag, ck_o, ck_oe, so, so_oe, miso, sfn;
  wire         sck = ck_oe ? ck_o : ext;
  int          error_cnt = 0, n_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  tws_channel i_tws_channel (.core_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wd),
    .wr_i(wr), .enable_set_i(es), .rd_i(rd), .rdata_o(rdata), .transfer_end_flag_o(flag),
    .flag_clr_i(clr), .ch1_clock_pin_i(sck), .ch1_clock_pin_o(ck_o), .ch1_clock_pin_oe_o(ck_oe),
    .ch1_serial_out_o(so), .ch1_serial_out_oe_o(so_oe), .ch1_serial_in_i(miso),
    .serial_function_o(sfn));
  tws_peer i_tws_peer (.sck_i(sck), .mosi_i(so), .load_i(ld), .tx_i(ptx), .miso_o(miso),
    .rx_o(prx));
  // ---------
  // tasks
  // ---------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // strobe held through the taking edge, read data caught just after it
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) #1 addr = a;
    wd = d;
    wr = w;
    rd = !w;
    @(posedge clk) #1 wr = 0;
    rd = 0;
    rdv = rdata;
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk) #1 s = 1;
    @(posedge clk) #1 s = 0;
  endtask
  // bounded wait: a stuck channel fails here, not at the timeout
  task automatic wait_flag(input logic e);
    repeat (400) if (flag !== 1'b1) @(posedge clk) #1;
    chk({7'h00, flag}, {7'h00, e});
  endtask
  task automatic nostart;
    acc(1, `TWS_MODE_OFFSET, 8'h03);
    acc(1, `TWS_SHIFT_OFFSET, 8'h5A);
    chk({7'h00, sfn}, 8'h00);
    chk({7'h00, so_oe}, 8'h00);
    pulse(es);
    wait_flag(1'b0);
    chk({7'h00, sfn}, 8'h01);
    acc(0, `TWS_SHIFT_OFFSET, 8'h00);
    chk(rdv, 8'h5A);
    acc(0, `TWS_MODE_OFFSET, 8'h00);
    chk(rdv, 8'h00);
    acc(0, 12'hFFF, 8'h00);
    chk(rdv, 8'h00);
  endtask
  // external clock is toggled by the bench, ten cycles a half period
  task automatic xfer(input logic [7:0] m, input logic [7:0] d, input logic [7:0] p);
    acc(1, `TWS_MODE_OFFSET, m);
    ptx = p;
    ld = 1;
    #1 ld = 0;
    acc(1, `TWS_SHIFT_OFFSET, d);
    chk({7'h00, ck_oe}, {7'h00, m[1]});
    if (!m[1]) repeat (16) begin
      repeat (10) @(posedge clk);
      #1 ext = ~ext;
    end
    wait_flag(1'b1);
    chk(prx, d);
    acc(0, `TWS_SHIFT_OFFSET, 8'h00);
    chk(rdv, p);
    pulse(clr);
    chk({7'h00, flag}, 8'h00);
  endtask
  // ---------
  // sequence and timeout
  // ---------
  initial begin
    repeat (8) @(posedge clk);
    #1 rst = 0;
    chk({4'h0, flag, ck_o, ck_oe, sfn}, 8'h04);
    nostart;
    xfer(8'h83, 8'hA5, 8'h3C);
    xfer(8'h82, 8'h81, 8'h7E);
    xfer(8'h80, 8'h4B, 8'hD2);
    close_out;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out;
    end
  end
endmodule // tws_channel_tb_top
`default_nettype wire
